// file: rtl/vic_arbiter.sv
`timescale 1ns/10ps
`include "vic_cfg.svh"
module vic_arbiter
    import vic_pkg::*;
(
    vic_src_if.arb sif,
    output logic nmi_pend,
    output logic mk_valid,
    output vic_vec_t mk_vec,
    output logic [1:0] mk_lvl
);
    assign nmi_pend = sif.req[1];

    // Both loops run downward so the last hit is the most urgent level
    // and, within it, the lowest vector number.
    always_comb begin
        mk_valid = 1'b0;
        mk_vec = '0;
        mk_lvl = '0;
        for (int l = 2; l >= 0; l--) begin
            for (int v = `VIC_VEC_MLAST; v >= `VIC_VEC_MFIRST; v--) begin
                if (sif.req[v] && sif.en[v] && sif.lvl[v] == 2'(l)) begin // [RQ20]
                    mk_valid = 1'b1;
                    mk_vec = 5'(v); // [RQ13]
                    mk_lvl = 2'(l);
                end
            end
        end
    end
endmodule : vic_arbiter

// file: rtl/vic_cfg.svh
`ifndef VIC_CFG_SVH
`define VIC_CFG_SVH
// ----------------------------------------------------------------
// Vector numbering
// ----------------------------------------------------------------
`define VIC_VEC_W 5
`define VIC_ADDR_W 20
`define VIC_VEC_RESET 5'h00
`define VIC_VEC_NMI 5'h01
`define VIC_VEC_MFIRST 2
`define VIC_VEC_MLAST 28
`define VIC_MASK_CNT 27
`define VIC_EXT_CNT 5
`define VIC_PER_CNT 22
// ----------------------------------------------------------------
// Vector table: entries are four bytes apart
// ----------------------------------------------------------------
`define VIC_TBL_BASE 20'h04000
`define VIC_TBL_SHIFT 2
// ----------------------------------------------------------------
// Source control byte layout
// ----------------------------------------------------------------
`define VIC_CR_REQ 0
`define VIC_CR_EN 1
`define VIC_CR_LV_LO 6
`define VIC_CR_LV_HI 7
`define VIC_LV_OFF 2'h3
`define VIC_LV_RST 2'h0
// ----------------------------------------------------------------
// Status word layout and reset
// ----------------------------------------------------------------
`define VIC_PSW_IM_LO 4
`define VIC_PSW_IM_HI 5
`define VIC_PSW_MIE 6
`define VIC_PSW_RST 8'h00
`define VIC_IM_NMI 2'h0
// ----------------------------------------------------------------
// Timing bounds in machine cycles (one machine cycle is one clk)
// ----------------------------------------------------------------
`define VIC_ENTRY_MAX 12
`define VIC_RTI_MAX 11
`endif

// file: rtl/vic_pkg.sv
`include "vic_cfg.svh"
package vic_pkg;
    typedef logic [`VIC_VEC_W-1:0] vic_vec_t;
    typedef logic [`VIC_ADDR_W-1:0] vic_addr_t;

    typedef enum logic [6:0] {
        VIC_ST_IDLE = 7'h01,
        VIC_ST_SAVE_HA = 7'h02,
        VIC_ST_SAVE_PC = 7'h04,
        VIC_ST_SAVE_PSW = 7'h08,
        VIC_ST_FETCH = 7'h10,
        VIC_ST_LOAD = 7'h20,
        VIC_ST_RTI = 7'h40
    } vic_state_t;

    typedef enum logic [1:0] {
        VIC_PUSH_HA = 2'h0,
        VIC_PUSH_PC = 2'h1,
        VIC_PUSH_PSW = 2'h2
    } vic_push_t;

    typedef struct packed {
        logic [`VIC_VEC_MLAST:1] req;
        logic [`VIC_VEC_MLAST:2] en;
        logic [`VIC_VEC_MLAST:2][1:0] lvl;
    } vic_bank_st_t;

    typedef struct packed {
        vic_state_t st;
        logic busy;
        vic_vec_t vec;
        logic [7:0] psw;
        logic [7:0] psw_sav;
        logic [`VIC_EXT_CNT-1:0] sync1;
        logic [`VIC_EXT_CNT-1:0] sync2;
        logic [`VIC_EXT_CNT-1:0] pin_q;
        logic accept_valid;
        vic_vec_t accept_vec;
        logic push_valid;
        vic_push_t push_kind;
        vic_addr_t push_data;
        logic vec_rd_en;
        vic_addr_t vec_rd_addr;
        logic branch_valid;
        vic_addr_t branch_addr;
    } vic_top_st_t;

    function automatic vic_addr_t vic_tbl_addr(input vic_vec_t v);
        return `VIC_TBL_BASE + (vic_addr_t'(v) << `VIC_TBL_SHIFT);
    endfunction : vic_tbl_addr

    // Level 0 is the most urgent; level 3 never wins.
    function automatic logic vic_lvl_beats(input logic [1:0] lv, input logic [1:0] im);
        return (lv != `VIC_LV_OFF) && (lv < im);
    endfunction : vic_lvl_beats
endpackage : vic_pkg

// file: rtl/vic_src_bank.sv
`timescale 1ns/10ps
`include "vic_cfg.svh"
module vic_src_bank
    import vic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    vic_src_if.bank sif
);
    vic_bank_st_t s_r;
    vic_bank_st_t s_nxt;

    // ----------------------------------------------------------------
    // Flag update: software write, then acceptance clear, then set
    // ----------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        if (sif.wr_en) begin
            if (sif.wr_vec == `VIC_VEC_NMI) begin
                s_nxt.req[1] = sif.wr_data[`VIC_CR_REQ]; // [RQ9]
            end else if (sif.wr_vec >= `VIC_VEC_MFIRST && sif.wr_vec <= `VIC_VEC_MLAST) begin
                s_nxt.req[sif.wr_vec] = sif.wr_data[`VIC_CR_REQ]; // [RQ9] [RQ7]
                s_nxt.en[sif.wr_vec] = sif.wr_data[`VIC_CR_EN]; // [RQ7]
                s_nxt.lvl[sif.wr_vec] = sif.wr_data[`VIC_CR_LV_HI:`VIC_CR_LV_LO]; // [RQ12]
            end
        end
        // Only the request flag is cleared; the enable stays as written.
        if (sif.clr_en) begin
            s_nxt.req[sif.clr_vec] = 1'b0; // [RQ8] [RQ19]
        end
        // A new request in the same cycle as a clear or a write is kept.
        s_nxt.req = s_nxt.req | sif.hw_set; // [RQ8] [RQ23]
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sif.req = s_r.req;
    assign sif.en = s_r.en;
    assign sif.lvl = s_r.lvl;
endmodule : vic_src_bank

// file: rtl/vic_src_if.sv
`timescale 1ns/10ps
`include "vic_cfg.svh"
interface vic_src_if;
    import vic_pkg::*;
    logic [`VIC_VEC_MLAST:1] hw_set;
    logic wr_en;
    vic_vec_t wr_vec;
    logic [7:0] wr_data;
    logic clr_en;
    vic_vec_t clr_vec;
    logic [`VIC_VEC_MLAST:1] req;
    logic [`VIC_VEC_MLAST:2] en;
    logic [`VIC_VEC_MLAST:2][1:0] lvl;

    modport bank (
        input hw_set, wr_en, wr_vec, wr_data, clr_en, clr_vec,
        output req, en, lvl
    );
    modport arb (
        input req, en, lvl
    );
    modport ctl (
        output hw_set, wr_en, wr_vec, wr_data, clr_en, clr_vec,
        input req, en, lvl
    );
endinterface : vic_src_if

// file: rtl/vic_top.sv
`timescale 1ns/10ps
`include "vic_cfg.svh"
// Functional notes
// [RQ1] Handler address is fetched from the vector table by hardware.
// [RQ2] Entries four bytes apart: reset 0, NMI 1, maskable 2 to 28.
// [RQ3] Except for reset, push PC, status word and handy address first.
// [RQ4] Interrupt return restores status word and return address.
// [RQ5] Entry completes within 12 machine cycles of the request.
// [RQ6] Return completes within 11 machine cycles.
// [RQ7] Each source has a control byte: level, enable, request flag.
// [RQ8] Request flag set by the source, cleared on acceptance.
// [RQ9] Software may write the request flag either way.
// [RQ10] NMI has no enable; a set NMI flag is always accepted.
// [RQ11] Maskable requests need the global maskable enable set.
// [RQ12] Software sets each maskable level to 0, 1 or 2.
// [RQ13] Equal levels: the lowest vector number wins.
// [RQ14] Maskable level must be more urgent than the mask level.
// [RQ15] NMI ignores the mask level.
// [RQ16] Reset comes from the pin; all status word flags clear.
// [RQ17] Accepting NMI clears the mask level to 00.
// [RQ18] Accepting maskable copies its level into the mask level.
// [RQ19] Acceptance leaves the enable bit unchanged.
// [RQ20] Level 3 is never accepted.
// [RQ21] NMI wins over pending maskable requests.
// [RQ22] Reset sets the mask level to 00.
// [RQ23] A hardware set beats a same-cycle software flag write.
// [RQ24] Winner and vector are registered and held through context save.
module vic_top
    import vic_pkg::*;
#(
    parameter int N_EXT = `VIC_EXT_CNT,
    parameter int N_PER = `VIC_PER_CNT
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [N_EXT-1:0] ext_irq_pin,
    input wire logic [N_PER-1:0] periph_req,
    input wire logic nmi_req,
    input wire logic cr_wr_en,
    input wire vic_vec_t cr_wr_vec,
    input wire logic [7:0] cr_wr_data,
    input wire logic psw_wr_en,
    input wire logic [7:0] psw_wr_data,
    input wire vic_addr_t core_pc,
    input wire logic [15:0] core_ha,
    input wire vic_addr_t vec_rd_data,
    input wire logic rti_start,
    input wire logic [7:0] rti_psw,
    input wire vic_addr_t rti_pc,
    output logic accept_valid,
    output vic_vec_t accept_vec,
    output logic busy,
    output logic push_valid,
    output vic_push_t push_kind,
    output vic_addr_t push_data,
    output logic vec_rd_en,
    output vic_addr_t vec_rd_addr,
    output logic branch_valid,
    output vic_addr_t branch_addr,
    output logic [7:0] psw_out,
    output logic [`VIC_VEC_MLAST:1] req_flags,
    output logic [`VIC_VEC_MLAST:2] en_flags,
    output logic [`VIC_VEC_MLAST:2][1:0] lvl_flags
);
    // ----------------------------------------------------------------
    // Elaboration check
    // ----------------------------------------------------------------
    // The flag bank is sized for exactly 27 maskable sources.
    if (N_EXT != `VIC_EXT_CNT || N_PER != `VIC_PER_CNT) begin : g_bad_cfg
        $error("vic_top: source counts do not match the flag bank");
    end

    // Pins and peripherals must fill the maskable vectors exactly.
    if (`VIC_EXT_CNT + `VIC_PER_CNT != `VIC_MASK_CNT) begin : g_bad_span
        $error("vic_top: maskable source count mismatch");
    end

    if (`VIC_VEC_MLAST - `VIC_VEC_MFIRST + 1 != `VIC_MASK_CNT) begin : g_bad_vec
        $error("vic_top: maskable vector range mismatch");
    end

    // Entry needs seven cycles and return two; bounds under seven or three fail.
    if (`VIC_ENTRY_MAX < 7 || `VIC_RTI_MAX < 3) begin : g_bad_time
        $error("vic_top: timing bounds shorter than the sequencer");
    end

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    vic_src_if sif ();

    logic nmi_pend;
    logic mk_valid;
    vic_vec_t mk_vec;
    logic [1:0] mk_lvl;

    // The bank holds every control byte; the arbiter only reads it.
    vic_src_bank u_bank (
        .clk(clk),
        .rst_b(rst_b),
        .sif(sif.bank)
    );

    // Pure logic: the winner is registered by the sequencer, not here.
    vic_arbiter u_arb (
        .sif(sif.arb),
        .nmi_pend(nmi_pend),
        .mk_valid(mk_valid),
        .mk_vec(mk_vec),
        .mk_lvl(mk_lvl)
    );

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    vic_top_st_t s_r;
    vic_top_st_t s_nxt;
    logic [N_EXT-1:0] ext_rise;
    logic take_nmi;
    logic take_mk;
    logic idle_free;

    // ----------------------------------------------------------------
    // Status word helpers
    // ----------------------------------------------------------------
    function automatic logic [1:0] mask_of(input logic [7:0] w);
        return w[`VIC_PSW_IM_HI:`VIC_PSW_IM_LO];
    endfunction : mask_of

    function automatic logic mie_of(input logic [7:0] w);
        return w[`VIC_PSW_MIE];
    endfunction : mie_of

    // Writes only the mask field, so a same-cycle program write keeps its
    // other bits while the accepted level still wins the mask.
    function automatic logic [7:0] with_mask(input logic [7:0] w, input logic [1:0] m);
        logic [7:0] r;
        r = w;
        r[`VIC_PSW_IM_HI:`VIC_PSW_IM_LO] = m;
        return r;
    endfunction : with_mask

    // ----------------------------------------------------------------
    // Acceptance
    // ----------------------------------------------------------------
    // Pins are edge-detected only after the two synchroniser stages.
    assign ext_rise = s_r.sync2 & ~s_r.pin_q;

    // A return request owns the idle slot; pending flags simply wait.
    assign idle_free = (s_r.st == VIC_ST_IDLE) && !rti_start;

    assign take_nmi = idle_free && nmi_pend; // [RQ10] [RQ21]
    assign take_mk = idle_free && !nmi_pend && mk_valid
        && mie_of(s_r.psw) // [RQ11]
        && vic_lvl_beats(mk_lvl, mask_of(s_r.psw)); // [RQ14] [RQ20]

    // ----------------------------------------------------------------
    // Flag bank connections
    // ----------------------------------------------------------------
    // Bit 1 is the NMI, bits 2 to 6 the pins, the rest peripherals.
    assign sif.hw_set = {periph_req, ext_rise, nmi_req}; // [RQ8]
    assign sif.wr_en = cr_wr_en; // [RQ9]
    assign sif.wr_vec = cr_wr_vec;
    assign sif.wr_data = cr_wr_data;
    assign sif.clr_en = take_nmi || take_mk; // [RQ8]
    assign sif.clr_vec = take_nmi ? `VIC_VEC_NMI : mk_vec;

    // ----------------------------------------------------------------
    // Sequencer
    // ----------------------------------------------------------------
    // Entry takes acceptance, three pushes, a table read and the branch,
    // seven cycles from the request pulse, well inside the bound.
    always_comb begin
        // Pulses drop after one cycle; data fields hold their last value.
        s_nxt = s_r;
        s_nxt.sync1 = ext_irq_pin;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.pin_q = s_r.sync2;
        s_nxt.accept_valid = 1'b0;
        s_nxt.push_valid = 1'b0;
        s_nxt.vec_rd_en = 1'b0;
        s_nxt.branch_valid = 1'b0;
        // A program write is applied first; an acceptance below then
        // overrides the mask field of the same cycle.
        if (psw_wr_en) begin
            s_nxt.psw = psw_wr_data;
        end

        case (s_r.st)
            VIC_ST_IDLE: begin
                // Return does not wait for pending requests; they are taken
                // once the sequencer is back in idle.
                if (rti_start) begin
                    s_nxt.psw = rti_psw; // [RQ4]
                    s_nxt.branch_addr = rti_pc; // [RQ4]
                    s_nxt.st = VIC_ST_RTI;
                end else if (take_nmi) begin
                    s_nxt.psw_sav = s_r.psw;
                    s_nxt.psw = with_mask(s_nxt.psw, `VIC_IM_NMI); // [RQ15] [RQ17]
                    s_nxt.vec = `VIC_VEC_NMI; // [RQ24]
                    s_nxt.accept_valid = 1'b1;
                    s_nxt.accept_vec = `VIC_VEC_NMI;
                    s_nxt.st = VIC_ST_SAVE_HA;
                end else if (take_mk) begin
                    s_nxt.psw_sav = s_r.psw;
                    s_nxt.psw = with_mask(s_nxt.psw, mk_lvl); // [RQ18]
                    s_nxt.vec = mk_vec; // [RQ24]
                    s_nxt.accept_valid = 1'b1;
                    s_nxt.accept_vec = mk_vec;
                    s_nxt.st = VIC_ST_SAVE_HA;
                end
            end

            // Handy address first, then return address, then status word.
            VIC_ST_SAVE_HA: begin
                s_nxt.push_valid = 1'b1; // [RQ3]
                s_nxt.push_kind = VIC_PUSH_HA;
                s_nxt.push_data = vic_addr_t'(core_ha);
                s_nxt.st = VIC_ST_SAVE_PC;
            end

            VIC_ST_SAVE_PC: begin
                s_nxt.push_valid = 1'b1; // [RQ3]
                s_nxt.push_kind = VIC_PUSH_PC;
                s_nxt.push_data = core_pc;
                s_nxt.st = VIC_ST_SAVE_PSW;
            end

            // The status word as it stood before acceptance changed the mask.
            VIC_ST_SAVE_PSW: begin
                s_nxt.push_valid = 1'b1; // [RQ3]
                s_nxt.push_kind = VIC_PUSH_PSW;
                s_nxt.push_data = vic_addr_t'(s_r.psw_sav);
                s_nxt.st = VIC_ST_FETCH;
            end

            // Reset enters here too, with vector 0 and no pushes.
            VIC_ST_FETCH: begin
                s_nxt.vec_rd_en = 1'b1; // [RQ1]
                s_nxt.vec_rd_addr = vic_tbl_addr(s_r.vec); // [RQ2]
                s_nxt.st = VIC_ST_LOAD;
            end

            VIC_ST_LOAD: begin
                // Table memory answers in the same cycle as the read strobe.
                s_nxt.branch_valid = 1'b1; // [RQ1] [RQ5]
                s_nxt.branch_addr = vec_rd_data;
                s_nxt.st = VIC_ST_IDLE;
            end

            // Status word was restored on entry; only the branch remains.
            VIC_ST_RTI: begin
                s_nxt.branch_valid = 1'b1; // [RQ6]
                s_nxt.st = VIC_ST_IDLE;
            end

            // Unreachable with one-hot codes; a stray state returns to idle.
            default: begin
                s_nxt.st = VIC_ST_IDLE;
            end
        endcase

        // Registered so the core reads busy straight from a flop.
        s_nxt.busy = (s_nxt.st != VIC_ST_IDLE);
    end

    // Reset starts straight at the table read for vector 0 with no pushes,
    // since there is no context worth saving.
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            s_r <= '0; // [RQ16] [RQ22]
            s_r.psw <= `VIC_PSW_RST; // [RQ16]
            s_r.vec <= `VIC_VEC_RESET; // [RQ2]
            s_r.st <= VIC_ST_FETCH; // [RQ16]
            s_r.busy <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign accept_valid = s_r.accept_valid;
    assign accept_vec = s_r.accept_vec;

    assign busy = s_r.busy;

    assign push_valid = s_r.push_valid;
    assign push_kind = s_r.push_kind;
    assign push_data = s_r.push_data;

    assign vec_rd_en = s_r.vec_rd_en;
    assign vec_rd_addr = s_r.vec_rd_addr;

    assign branch_valid = s_r.branch_valid;
    assign branch_addr = s_r.branch_addr;

    assign psw_out = s_r.psw;

    assign req_flags = sif.req;
    assign en_flags = sif.en;
    assign lvl_flags = sif.lvl;
endmodule : vic_top

// file: verif/vectored_interrupt_controller_tb.sv
`timescale 1ns/10ps
`include "vic_cfg.svh"
module vectored_interrupt_controller_tb
    import vic_pkg::*;
;
    logic clk = 1'b0, rst_b = 1'b0, nmi_req = 1'b0, cr_wr_en = 1'b0, psw_wr_en = 1'b0;
    logic rti_start = 1'b0;
    logic [4:0] ext_irq_pin = '0;
    logic [21:0] periph_req = '0;
    vic_vec_t cr_wr_vec = '0;
    logic [7:0] cr_wr_data = '0, psw_wr_data = '0, rti_psw = '0, psw_out;
    vic_addr_t core_pc = 20'h12345, rti_pc = '0;
    logic [15:0] core_ha = 16'hbeef;
    logic accept_valid, busy, push_valid, vec_rd_en, branch_valid;
    vic_vec_t accept_vec;
    vic_push_t push_kind;
    vic_addr_t push_data, vec_rd_addr, vec_rd_data, branch_addr;
    logic [28:1] req_flags;
    logic [28:2] en_flags;
    logic [28:2][1:0] lvl_flags;
    int fails = 0;
    int compares = 0;
    always #2.5 clk = ~clk;
    vic_top dut (.clk, .rst_b, .ext_irq_pin, .periph_req, .nmi_req, .cr_wr_en, .cr_wr_vec,
        .cr_wr_data, .psw_wr_en, .psw_wr_data, .core_pc, .core_ha, .vec_rd_data, .rti_start,
        .rti_psw, .rti_pc, .accept_valid, .accept_vec, .busy, .push_valid, .push_kind,
        .push_data, .vec_rd_en, .vec_rd_addr, .branch_valid, .branch_addr, .psw_out,
        .req_flags, .en_flags, .lvl_flags);
    vic_core_model u_core (.clk, .rst_b, .vec_rd_en, .vec_rd_addr, .vec_rd_data);
    // ----
    // Helpers
    // ----
    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic stop_test();
        if (fails == 0 && compares > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : stop_test
    task automatic wr_cr(input vic_vec_t v, input logic [7:0] d);
        @(negedge clk);
        cr_wr_en = 1'b1;
        cr_wr_vec = v;
        cr_wr_data = d;
        @(negedge clk);
        cr_wr_en = 1'b0;
    endtask : wr_cr
    task automatic wr_psw(input logic [7:0] d);
        @(negedge clk);
        psw_wr_en = 1'b1;
        psw_wr_data = d;
        @(negedge clk);
        psw_wr_en = 1'b0;
    endtask : wr_psw
    task automatic quiet(input int n);
        repeat (n) begin
            @(negedge clk);
            chk("no_accept", 20'h0, 20'(accept_valid));
        end
    endtask : quiet
    task automatic wait_branch();
        for (int n = 0; n < 8 && branch_valid !== 1'b1; n++) begin
            @(negedge clk);
        end
    endtask : wait_branch
    // The 12-cycle wait starts when entry is called, so a slow acceptance is a mismatch.
    task automatic entry(input vic_vec_t v, input logic [1:0] im, input logic [7:0] psw0);
        vic_addr_t exp[3];
        exp[0] = {4'h0, core_ha};
        exp[1] = core_pc;
        exp[2] = {12'h000, psw0};
        for (int n = 0; n < 12 && accept_valid !== 1'b1; n++) begin
            @(negedge clk);
        end
        chk("accept", 20'(v) + 20'h100, {accept_valid, 8'h00} + 20'(accept_vec));
        chk("mask", 20'(im), 20'(psw_out[5:4]));
        chk("req_clear", 20'h0, 20'(req_flags[v]));
        chk("busy", 20'h1, 20'(busy));
        for (int k = 0; k < 3; k++) begin
            @(negedge clk);
            chk("push_kind", 20'(k + 4), 20'({push_valid, push_kind}));
            chk("push_data", exp[k], push_data);
        end
        wait_branch();
        chk("branch", 20'h84000 + {v, 2'b00}, branch_addr);
        chk("idle", 20'h0, 20'(busy));
    endtask : entry
    task automatic interrupt_return_instr(input logic [7:0] psw, input vic_addr_t pc);
        @(negedge clk);
        rti_start = 1'b1;
        rti_psw = psw;
        rti_pc = pc;
        @(negedge clk);
        rti_start = 1'b0;
        chk("rti_psw", 20'(psw), 20'(psw_out));
        @(negedge clk);
        chk("rti_pc", pc, branch_valid ? branch_addr : 20'hfffff);
    endtask : interrupt_return_instr
    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        wait_branch();
        chk("reset_branch", 20'h84000, branch_addr);
        chk("reset_psw", 20'h0, 20'(psw_out));
        chk("reset_req", 20'h0, req_flags[20:1]);
    endtask : t_reset
    task automatic t_nmi();
        wr_psw(8'h70);
        wr_cr(5'd7, 8'h02);
        @(negedge clk);
        nmi_req = 1'b1;
        periph_req[0] = 1'b1;
        @(negedge clk);
        nmi_req = 1'b0;
        periph_req[0] = 1'b0;
        entry(5'd1, 2'h0, 8'h70);
        quiet(6);
        chk("pend7", 20'h1, 20'(req_flags[7]));
        interrupt_return_instr(8'h70, 20'h0abcd);
        entry(5'd7, 2'h0, 8'h70);
        chk("en7", 20'h1, 20'(en_flags[7]));
        interrupt_return_instr(8'h70, 20'h0abce);
    endtask : t_nmi
    task automatic t_levels();
        wr_psw(8'h30);
        wr_cr(5'd9, 8'h43);
        wr_cr(5'd5, 8'h43);
        wr_cr(5'd4, 8'h83);
        wr_cr(5'd3, 8'hc3);
        chk("sw_set", 20'h1, 20'(req_flags[5]));
        wr_psw(8'h70);
        entry(5'd5, 2'h1, 8'h70);
        quiet(6);
        interrupt_return_instr(8'h70, 20'h01000);
        entry(5'd9, 2'h1, 8'h70);
        interrupt_return_instr(8'h70, 20'h01001);
        entry(5'd4, 2'h2, 8'h70);
        interrupt_return_instr(8'h70, 20'h01002);
        quiet(8);
        wr_cr(5'd3, 8'hc2);
        chk("sw_clr", 20'h0, 20'(req_flags[3]));
    endtask : t_levels
    task automatic t_mie();
        wr_psw(8'h30);
        @(negedge clk);
        periph_req[3] = 1'b1;
        cr_wr_en = 1'b1;
        cr_wr_vec = 5'd10;
        cr_wr_data = 8'h02;
        @(negedge clk);
        periph_req[3] = 1'b0;
        cr_wr_en = 1'b0;
        quiet(6);
        chk("hw_wins", 20'h1, 20'(req_flags[10]));
        wr_psw(8'h70);
        entry(5'd10, 2'h0, 8'h70);
        interrupt_return_instr(8'h70, 20'h02000);
        ext_irq_pin[1] = 1'b1;
        quiet(6);
        chk("pin_set", 20'h1, 20'(req_flags[3]));
    endtask : t_mie
    initial begin
        repeat (3000) @(posedge clk);
        fails++;
        stop_test();
    end
    initial begin
        repeat (12) @(negedge clk);
        rst_b = 1'b1;
        t_reset();
        t_nmi();
        t_levels();
        t_mie();
        stop_test();
    end
endmodule : vectored_interrupt_controller_tb

// file: verif/vic_core_model.sv
`timescale 1ns/10ps
module vic_core_model
    import vic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic vec_rd_en,
    input wire vic_addr_t vec_rd_addr,
    output vic_addr_t vec_rd_data
);
    // ----
    // Vector table
    // ----
    // Outside a read and the cycle after it the bus carries a pattern that changes every cycle, so a sample two or more cycles late shows.
    logic hold_r;
    vic_addr_t addr_r;
    vic_addr_t junk_r;
    always_ff @(posedge clk) begin
        hold_r <= rst_b && vec_rd_en;
        addr_r <= vec_rd_addr;
        junk_r <= rst_b ? ~junk_r : 20'h5a5a5;
    end
    assign vec_rd_data = vec_rd_en ? (vec_rd_addr | 20'h80000) :
        (hold_r ? (addr_r | 20'h80000) : junk_r);
endmodule : vic_core_model

// file: verif/vic_top_assertions.sv
`timescale 1ns/10ps
`include "vic_cfg.svh"
module vic_top_assertions
    import vic_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic rti_start,
    input wire logic [7:0] rti_psw,
    input wire vic_addr_t rti_pc,
    input wire logic accept_valid,
    input wire vic_vec_t accept_vec,
    input wire logic busy,
    input wire logic push_valid,
    input wire vic_push_t push_kind,
    input wire logic vec_rd_en,
    input wire vic_addr_t vec_rd_addr,
    input wire logic branch_valid,
    input wire vic_addr_t branch_addr,
    input wire logic [7:0] psw_out,
    input wire logic [`VIC_VEC_MLAST:1] req_flags,
    input wire logic [`VIC_VEC_MLAST:2][1:0] lvl_flags
);
    // ----
    // Port relations
    // ----
    default clocking dc @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    AST_VEC_ADDR: assert property (
        vec_rd_en |-> vec_rd_addr == 20'h04000 + {accept_vec, 2'b00})
        else $error("bad vector address");
    AST_PUSH_ORDER: assert property (
        accept_valid && accept_vec != 5'h00 |=> push_valid && push_kind == VIC_PUSH_HA
        ##1 push_valid && push_kind == VIC_PUSH_PC ##1 push_valid && push_kind == VIC_PUSH_PSW)
        else $error("bad push order");
    AST_ENTRY_TIME: assert property (
        $rose(req_flags[1]) && !busy |-> ##[1:12] accept_valid)
        else $error("entry too slow");
    AST_RTI: assert property (
        rti_start && !busy |=> psw_out == $past(rti_psw)
        ##1 branch_valid && branch_addr == $past(rti_pc, 2))
        else $error("bad return");
    AST_NMI_MASK: assert property (
        accept_valid && accept_vec == `VIC_VEC_NMI |-> psw_out[5:4] == 2'h0)
        else $error("mask not cleared");
    AST_MK_ACCEPT: assert property (
        accept_valid && accept_vec >= 5'h02 |-> psw_out[5:4] == lvl_flags[accept_vec]
        && lvl_flags[accept_vec] < $past(psw_out[5:4]) && $past(psw_out[6]))
        else $error("bad maskable accept");
    AST_REQ_CLEAR: assert property (
        accept_valid |-> !req_flags[accept_vec])
        else $error("flag not cleared");
    AST_NMI_FIRST: assert property (
        accept_valid && $past(req_flags[1]) |-> accept_vec == `VIC_VEC_NMI)
        else $error("nmi lost");
    AST_HOLD: assert property (
        accept_valid |=> (!accept_valid && $stable(accept_vec)) [*5])
        else $error("winner not held");
    AST_FETCH: assert property (
        vec_rd_en |=> branch_valid)
        else $error("no branch");
    AST_RESET: assert property (
        $rose(rst_b) |-> psw_out == `VIC_PSW_RST && req_flags == '0)
        else $error("bad reset state");
    CV_NMI: cover property (accept_valid && accept_vec == 5'h01);
    CV_MK: cover property (accept_valid && accept_vec > 5'h01);
    CV_RTI: cover property (rti_start && !busy);
endmodule : vic_top_assertions
bind vic_top vic_top_assertions u_vic_chk (.clk, .rst_b, .rti_start, .rti_psw, .rti_pc,
    .accept_valid, .accept_vec, .busy, .push_valid, .push_kind, .vec_rd_en, .vec_rd_addr,
    .branch_valid, .branch_addr, .psw_out, .req_flags, .lvl_flags);
